/* File: hdl/remote_command_interpreter.sv */
// Remote command interpreter: frame parser, settings and query replies
`include "rci_consts.svh"
module remote_command_interpreter #(
   parameter int VAL_W = 20
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_rx_valid,
   input  wire logic [7:0]       i_rx_data,
   input  wire logic             i_tx_ready,
   input  wire logic             i_remote_mode,
   input  wire logic             i_multidrop,
   input  wire logic [9:0]       i_dev_addr,
   input  wire logic             i_alarm,
   output logic                  o_tx_valid,
   output logic [7:0]            o_tx_data,
   output logic                  o_run,
   output logic                  o_remote_stopped,
   output logic [1:0]            o_active_setpoint,
   output logic [1:0]            o_tuning_mode,
   output logic                  o_prog_input_current,
   output logic                  o_ext_control,
   output logic [VAL_W-1:0]      o_working_setpoint_one,
   output logic [VAL_W-1:0]      o_working_setpoint_two,
   output logic [VAL_W-1:0]      o_working_setpoint_three,
   output logic                  o_alarm_relay,
   output logic                  o_nv_store
);
   if (VAL_W < 8 || VAL_W > 20) begin : g_chk
      $error("remote_command_interpreter: VAL_W must lie in 8..20");
   end

   rci_if #(.VAL_W(VAL_W)) rif ();

   reply_tx #(.VAL_W(VAL_W)) u_reply (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .rif        (rif)
   );

   rci_pkg::parse_state_t st_r, st_nxt, st_eff;
   logic [8*`CMD_MAX-1:0] cmd_r, cmd_nxt;
   logic [3:0]            len_r, len_nxt;
   logic [9:0]            addr_r, addr_nxt;
   logic [1:0]            acnt_r, acnt_nxt;
   logic [19:0]           val_r, val_nxt;
   logic [1:0]            frac_r, frac_nxt;
   logic                  neg_r, neg_nxt, dot_r, dot_nxt;
   logic                  pdig_r, pdig_nxt, bad_r, bad_nxt;
   logic                  exec;
   logic [7:0]            ch;
   logic                  is_dig;
   logic [3:0]            dval;

   logic signed [VAL_W-1:0] sp_r [3];
   logic signed [VAL_W-1:0] sp_nxt [3];
   logic signed [VAL_W-1:0] rval_r, rval_nxt;
   logic        run_r, run_nxt, rstop_r, rstop_nxt, remd_r;
   logic [1:0]  asp_r, asp_nxt, tune_r, tune_nxt;
   logic        prog_r, prog_nxt, ext_r, ext_nxt;
   logic        alarm_r, nv_r, nv_nxt, start_r, start_nxt;

   assign ch = i_rx_data;
   assign is_dig = (ch >= `CH_ZERO) && (ch <= `CH_NINE);
   assign dval = 4'(ch - `CH_ZERO);

   //----------------------------------------------------------------
   // Frame parser
   //----------------------------------------------------------------
   always_comb begin
      st_eff = st_r;
      if (st_r == rci_pkg::P_SYNC) begin
         st_eff = i_multidrop ? rci_pkg::P_ADDR : rci_pkg::P_CMD;
      end
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      len_nxt = len_r;
      addr_nxt = addr_r;
      acnt_nxt = acnt_r;
      val_nxt = val_r;
      frac_nxt = frac_r;
      neg_nxt = neg_r;
      dot_nxt = dot_r;
      pdig_nxt = pdig_r;
      bad_nxt = bad_r;
      exec = 1'b0;
      if (st_r == rci_pkg::P_WAIT) begin
         // Bytes arriving while a reply goes out are dropped
         if (!start_r && !rif.busy) begin
            st_nxt = rci_pkg::P_SYNC;
         end
      end else if (i_rx_valid && ch == `CH_CR) begin
         exec = !bad_r && (st_eff == rci_pkg::P_CMD ||
                           st_eff == rci_pkg::P_PARAM) &&
                len_r != 4'h0;
         st_nxt = rci_pkg::P_SYNC;
         if (exec && start_nxt) begin
            st_nxt = rci_pkg::P_WAIT;
         end
         cmd_nxt = '0;
         len_nxt = 4'h0;
         addr_nxt = 10'h000;
         acnt_nxt = 2'h0;
         val_nxt = 20'h00000;
         frac_nxt = 2'h0;
         neg_nxt = 1'b0;
         dot_nxt = 1'b0;
         pdig_nxt = 1'b0;
         bad_nxt = 1'b0;
      end else if (i_rx_valid) begin
         unique case (st_eff)
            rci_pkg::P_ADDR: begin
               st_nxt = rci_pkg::P_ADDR;
               if (acnt_r == 2'h0 && !len_r[3] && ch == `CH_ADDR &&
                   addr_r == 10'h000 && !pdig_r) begin
                  pdig_nxt = 1'b1;
               end else if (pdig_r && is_dig) begin
                  addr_nxt = 10'(addr_r * 10'd10 + {6'h00, dval});
                  acnt_nxt = acnt_r + 2'h1;
                  if (acnt_r == 2'(`ADDR_DIGITS - 1)) begin
                     st_nxt = rci_pkg::P_CMD;
                     pdig_nxt = 1'b0;
                  end
               end else begin
                  st_nxt = rci_pkg::P_SKIP;
               end
            end
            rci_pkg::P_SYNC, rci_pkg::P_CMD: begin
               st_nxt = rci_pkg::P_CMD;
               if (ch == `CH_SPACE && len_r != 4'h0) begin
                  st_nxt = rci_pkg::P_PARAM;
               end else if (len_r == 4'h0 && i_multidrop &&
                            (ch == `CH_SEP || ch == `CH_SPACE)) begin
                  st_nxt = rci_pkg::P_CMD;
               end else if (len_r < 4'(`CMD_MAX)) begin
                  cmd_nxt = {cmd_r[8*`CMD_MAX-9:0], ch};
                  len_nxt = len_r + 4'h1;
               end else begin
                  st_nxt = rci_pkg::P_SKIP;
               end
            end
            rci_pkg::P_PARAM: begin
               if (ch == `CH_MINUS && !pdig_r && !neg_r && !dot_r) begin
                  neg_nxt = 1'b1;
               end else if (ch == `CH_PERIOD && !dot_r) begin
                  dot_nxt = 1'b1;
               end else if (is_dig) begin
                  pdig_nxt = 1'b1;
                  if (!dot_r || frac_r < 2'(`FRAC_DIGITS)) begin
                     val_nxt = 20'(val_r * 20'd10 + {16'h0000, dval});
                  end
                  if (dot_r && frac_r < 2'(`FRAC_DIGITS)) begin
                     frac_nxt = frac_r + 2'h1;
                  end
               end else if (ch != `CH_SPACE) begin
                  bad_nxt = 1'b1;
               end
            end
            rci_pkg::P_SKIP: begin
               st_nxt = rci_pkg::P_SKIP;
            end
            rci_pkg::P_WAIT: begin
               st_nxt = rci_pkg::P_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= rci_pkg::P_SYNC;
         cmd_r <= '0;
         len_r <= 4'h0;
         addr_r <= 10'h000;
         acnt_r <= 2'h0;
         val_r <= 20'h00000;
         frac_r <= 2'h0;
         neg_r <= 1'b0;
         dot_r <= 1'b0;
         pdig_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         len_r <= len_nxt;
         addr_r <= addr_nxt;
         acnt_r <= acnt_nxt;
         val_r <= val_nxt;
         frac_r <= frac_nxt;
         neg_r <= neg_nxt;
         dot_r <= dot_nxt;
         pdig_r <= pdig_nxt;
         bad_r <= bad_nxt;
      end
   end

   //----------------------------------------------------------------
   // Command decode and settings
   //----------------------------------------------------------------
   always_comb begin
      logic        addr_ok, set_ok, intp, is_mode, is_osp, is_isp;
      logic [19:0] scaled;
      logic [7:0]  sel;
      logic [1:0]  idx;
      logic [3:0]  p;
      scaled = 20'h00000;
      addr_ok = !i_multidrop || addr_r == i_dev_addr;
      set_ok = exec && addr_ok && i_remote_mode && pdig_r;
      intp = !dot_r && !neg_r && val_r < 20'h00010;
      p = val_r[3:0];
      sel = cmd_r[7:0];
      idx = 2'(sel - `CH_ZERO);
      is_mode = len_r == `LEN_OUT_MODE &&
                cmd_r[8*`CMD_MAX-1:8] == `STR_OUT_MODE;
      is_osp = len_r == `LEN_OUT_SP && cmd_r[71:8] == `STR_OUT_SP;
      is_isp = len_r == `LEN_IN_SP && cmd_r[63:8] == `STR_IN_SP;
      unique case (frac_r)
         2'h0: scaled = 20'(val_r * 20'd100);
         2'h1: scaled = 20'(val_r * 20'd10);
         default: scaled = val_r;
      endcase
      for (int i = 0; i < 3; i++) begin
         sp_nxt[i] = sp_r[i];
      end
      run_nxt = run_r;
      asp_nxt = asp_r;
      tune_nxt = tune_r;
      prog_nxt = prog_r;
      ext_nxt = ext_r;
      nv_nxt = 1'b0;
      rval_nxt = rval_r;
      start_nxt = 1'b0;
      if (set_ok && is_mode && intp) begin
         unique case (sel)
            `MODE_SP_SEL: if (p <= 4'h2) asp_nxt = p[1:0];
            `MODE_TUNE:   if (p <= 4'h2) tune_nxt = p[1:0];
            `MODE_PROG:   if (p <= 4'h1) prog_nxt = p[0];
            `MODE_SOURCE: if (p <= 4'h1) ext_nxt = p[0];
            `MODE_RUN:    if (p <= 4'h1) run_nxt = p[0];
            default: ;
         endcase
         nv_nxt = sel != `MODE_RUN && p <= 4'h2;
      end
      if (set_ok && is_osp && !bad_r &&
          8'(sel - `CH_ZERO) <= {6'h00, `SP_THREE}) begin
         // Stored as hundredths of the current display unit
         sp_nxt[idx] = neg_r ? VAL_W'(-scaled) : VAL_W'(scaled);
         nv_nxt = 1'b1;
      end
      if (exec && addr_ok && is_isp && !pdig_r &&
          8'(sel - `CH_ZERO) <= {6'h00, `SP_THREE}) begin
         rval_nxt = sp_r[idx];
         start_nxt = 1'b1;
      end
      if (i_remote_mode && !remd_r) begin
         run_nxt = 1'b0;
      end
      rstop_nxt = i_remote_mode && !run_nxt;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < 3; i++) begin
            sp_r[i] <= '0;
         end
         run_r <= 1'b0;
         rstop_r <= 1'b0;
         remd_r <= 1'b0;
         asp_r <= `SP_ONE;
         tune_r <= `TUNE_OFF;
         prog_r <= 1'b0;
         ext_r <= 1'b0;
         alarm_r <= 1'b0;
         nv_r <= 1'b0;
         start_r <= 1'b0;
         rval_r <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            sp_r[i] <= sp_nxt[i];
         end
         run_r <= run_nxt;
         rstop_r <= rstop_nxt;
         remd_r <= i_remote_mode;
         asp_r <= asp_nxt;
         tune_r <= tune_nxt;
         prog_r <= prog_nxt;
         ext_r <= ext_nxt;
         alarm_r <= i_alarm;
         nv_r <= nv_nxt;
         start_r <= start_nxt;
         rval_r <= rval_nxt;
      end
   end

   assign rif.start = start_r;
   assign rif.value = rval_r;
   assign rif.addr_en = i_multidrop;
   assign rif.addr = i_dev_addr;
   assign rif.tx_ready = i_tx_ready;

   assign o_tx_valid = rif.tx_valid;
   assign o_tx_data = rif.tx_data;
   assign o_run = run_r;
   assign o_remote_stopped = rstop_r;
   assign o_active_setpoint = asp_r;
   assign o_tuning_mode = tune_r;
   assign o_prog_input_current = prog_r;
   assign o_ext_control = ext_r;
   assign o_working_setpoint_one = sp_r[0];
   assign o_working_setpoint_two = sp_r[1];
   assign o_working_setpoint_three = sp_r[2];
   assign o_alarm_relay = alarm_r;
   assign o_nv_store = nv_r;
endmodule

/* File: hdl/rci_consts.svh */
// Constants of the remote command interpreter
`ifndef RCI_CONSTS_SVH
`define RCI_CONSTS_SVH

`define CH_SPACE    8'h20
`define CH_CR       8'h0d
`define CH_LF       8'h0a
`define CH_PERIOD   8'h2e
`define CH_MINUS    8'h2d
`define CH_ADDR     8'h41
`define CH_SEP      8'h5f
`define CH_ZERO     8'h30
`define CH_NINE     8'h39

`define CMD_MAX     11
`define ADDR_DIGITS 3
`define FRAC_DIGITS 2

`define STR_OUT_MODE "out_mode_0"
`define STR_OUT_SP   "out_sp_0"
`define STR_IN_SP    "in_sp_0"
`define LEN_OUT_MODE 4'hb
`define LEN_OUT_SP   4'h9
`define LEN_IN_SP    4'h8

`define MODE_SP_SEL  8'h31
`define MODE_TUNE    8'h32
`define MODE_PROG    8'h33
`define MODE_SOURCE  8'h34
`define MODE_RUN     8'h35

`define SP_ONE       2'h0
`define SP_TWO       2'h1
`define SP_THREE     2'h2
`define TUNE_OFF     2'h0
`define TUNE_ONCE    2'h1
`define TUNE_ALWAYS  2'h2

`define DIG_POINT    3'h3
`define DIG_LAST     3'h5

`endif

/* File: hdl/rci_pkg.sv */
// Types of the remote command interpreter
package rci_pkg;
   typedef enum logic [2:0] {
      P_SYNC, P_ADDR, P_CMD, P_PARAM, P_SKIP, P_WAIT
   } parse_state_t;
   typedef enum logic [2:0] {
      R_IDLE, R_PREFIX, R_SEP, R_SIGN, R_DIG, R_POINT, R_LF
   } reply_state_t;
endpackage

/* File: hdl/rci_if.sv */
// Reply request and transmit stream between parser and reply generator
interface rci_if #(parameter int VAL_W = 20);
   logic                    start;
   logic signed [VAL_W-1:0] value;
   logic                    addr_en;
   logic [9:0]              addr;
   logic                    busy;
   logic                    tx_valid;
   logic [7:0]              tx_data;
   logic                    tx_ready;
   modport ctl (output start, value, addr_en, addr, tx_ready,
                input  busy, tx_valid, tx_data);
   modport rep (input  start, value, addr_en, addr, tx_ready,
                output busy, tx_valid, tx_data);
endinterface

/* File: hdl/reply_tx.sv */
// Reply string generator: address prefix, decimal value, line feed
`include "rci_consts.svh"
module reply_tx #(
   parameter int VAL_W = 20
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   rci_if.rep        rif
);
   if (VAL_W < 8 || VAL_W > 20) begin : g_chk
      $error("reply_tx: VAL_W must lie in 8..20");
   end

   rci_pkg::reply_state_t st_r, st_nxt;
   logic [19:0] mag_r, mag_nxt, rem_r, rem_nxt;
   logic [2:0]  idx_r, idx_nxt;
   logic [3:0]  dig_r, dig_nxt;
   logic        calc_r, calc_nxt, lead_r, lead_nxt;
   logic        aph_r, aph_nxt, neg_r, neg_nxt;
   logic        txv_r, txv_nxt;
   logic [7:0]  txd_r, txd_nxt;

   function automatic logic [19:0] pow10(input logic [2:0] i);
      logic [19:0] p;
      p = 20'h00001;
      case (i)
         3'h0: p = 20'h186a0;
         3'h1: p = 20'h02710;
         3'h2: p = 20'h003e8;
         3'h3: p = 20'h00064;
         3'h4: p = 20'h0000a;
         default: p = 20'h00001;
      endcase
      return p;
   endfunction

   assign rif.busy     = (st_r != rci_pkg::R_IDLE);
   assign rif.tx_valid = txv_r;
   assign rif.tx_data  = txd_r;

   //----------------------------------------------------------------
   // Character sequencer
   //----------------------------------------------------------------
   always_comb begin
      logic acc;
      logic [VAL_W-1:0] absv;
      acc = txv_r && rif.tx_ready;
      absv = rif.value[VAL_W-1] ? VAL_W'(-rif.value) : rif.value;
      st_nxt = st_r;
      mag_nxt = mag_r;
      rem_nxt = rem_r;
      idx_nxt = idx_r;
      dig_nxt = dig_r;
      calc_nxt = calc_r;
      lead_nxt = lead_r;
      aph_nxt = aph_r;
      neg_nxt = neg_r;
      txv_nxt = acc ? 1'b0 : txv_r;
      txd_nxt = txd_r;
      unique case (st_r)
         rci_pkg::R_IDLE: begin
            if (rif.start) begin
               mag_nxt = 20'(absv);
               neg_nxt = rif.value[VAL_W-1];
               st_nxt = rif.addr_en ? rci_pkg::R_PREFIX
                                    : rci_pkg::R_SIGN;
            end
         end
         rci_pkg::R_PREFIX: begin
            if (!txv_r) begin
               txv_nxt = 1'b1;
               txd_nxt = `CH_ADDR;
            end else if (acc) begin
               rem_nxt = 20'(rif.addr);
               idx_nxt = `DIG_POINT;
               lead_nxt = 1'b0;
               aph_nxt = 1'b1;
               st_nxt = rci_pkg::R_DIG;
            end
         end
         rci_pkg::R_SEP: begin
            if (!txv_r) begin
               txv_nxt = 1'b1;
               txd_nxt = `CH_SEP;
            end else if (acc) begin
               st_nxt = rci_pkg::R_SIGN;
            end
         end
         rci_pkg::R_SIGN: begin
            if (neg_r && !txv_r) begin
               txv_nxt = 1'b1;
               txd_nxt = `CH_MINUS;
            end else if (!neg_r || acc) begin
               rem_nxt = mag_r;
               idx_nxt = 3'h0;
               lead_nxt = 1'b1;
               aph_nxt = 1'b0;
               st_nxt = rci_pkg::R_DIG;
            end
         end
         rci_pkg::R_DIG: begin
            if (!calc_r) begin
               if (rem_r >= pow10(idx_r)) begin
                  rem_nxt = rem_r - pow10(idx_r);
                  dig_nxt = dig_r + 4'h1;
               end else begin
                  calc_nxt = 1'b1;
               end
            end else if (lead_r && dig_r == 4'h0 &&
                         idx_r < `DIG_POINT) begin
               calc_nxt = 1'b0;
               idx_nxt = idx_r + 3'h1;
            end else if (!txv_r) begin
               txv_nxt = 1'b1;
               txd_nxt = `CH_ZERO + {4'h0, dig_r};
            end else if (acc) begin
               calc_nxt = 1'b0;
               dig_nxt = 4'h0;
               lead_nxt = 1'b0;
               idx_nxt = idx_r + 3'h1;
               if (idx_r == `DIG_LAST) begin
                  st_nxt = aph_r ? rci_pkg::R_SEP : rci_pkg::R_LF;
               end else if (idx_r == `DIG_POINT && !aph_r) begin
                  st_nxt = rci_pkg::R_POINT;
               end
            end
         end
         rci_pkg::R_POINT: begin
            if (!txv_r) begin
               txv_nxt = 1'b1;
               txd_nxt = `CH_PERIOD;
            end else if (acc) begin
               st_nxt = rci_pkg::R_DIG;
            end
         end
         rci_pkg::R_LF: begin
            if (!txv_r) begin
               txv_nxt = 1'b1;
               txd_nxt = `CH_LF;
            end else if (acc) begin
               st_nxt = rci_pkg::R_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= rci_pkg::R_IDLE;
         mag_r <= 20'h00000;
         rem_r <= 20'h00000;
         idx_r <= 3'h0;
         dig_r <= 4'h0;
         calc_r <= 1'b0;
         lead_r <= 1'b0;
         aph_r <= 1'b0;
         neg_r <= 1'b0;
         txv_r <= 1'b0;
         txd_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         mag_r <= mag_nxt;
         rem_r <= rem_nxt;
         idx_r <= idx_nxt;
         dig_r <= dig_nxt;
         calc_r <= calc_nxt;
         lead_r <= lead_nxt;
         aph_r <= aph_nxt;
         neg_r <= neg_nxt;
         txv_r <= txv_nxt;
         txd_r <= txd_nxt;
      end
   end
endmodule

/* File: tb/rci_props.sv */
// Port checker of the remote command interpreter
module rci_props #(
   parameter int VAL_W = 20
) (
   input wire logic             i_core_clk,
   input wire logic             i_rst,
   input wire logic             i_rx_valid,
   input wire logic [7:0]       i_rx_data,
   input wire logic             i_tx_ready,
   input wire logic             i_remote_mode,
   input wire logic             i_alarm,
   input wire logic             o_tx_valid,
   input wire logic [7:0]       o_tx_data,
   input wire logic             o_run,
   input wire logic             o_remote_stopped,
   input wire logic [1:0]       o_active_setpoint,
   input wire logic [1:0]       o_tuning_mode,
   input wire logic [VAL_W-1:0] o_working_setpoint_one,
   input wire logic             o_alarm_relay,
   input wire logic             o_nv_store
);
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------
   // Reply allowed after a CR
   // -------------------------
   logic armed_r;
   logic armed_nxt;
   always_comb begin
      armed_nxt = armed_r;
      if (i_rx_valid && i_rx_data == 8'h0d) armed_nxt = 1'b1;
      else if (o_tx_valid && i_tx_ready && o_tx_data == 8'h0a)
         armed_nxt = 1'b0;
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) armed_r <= 1'b0;
      else armed_r <= armed_nxt;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   AST_ALARM_LAG: assert property (
      !$past(i_rst) |-> o_alarm_relay == $past(i_alarm))
      else $error("alarm relay not one cycle behind alarm");
   AST_TX_HOLD: assert property (
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("reply char dropped or changed while stalled");
   AST_NO_UNSOLICITED: assert property (
      $rose(o_tx_valid) |-> armed_r)
      else $error("transmit without a pending frame");
   AST_REMOTE_STOP: assert property (
      $rose(i_remote_mode) |-> ##[1:2] (!o_run && o_remote_stopped))
      else $error("remote entry did not stop the unit");
   AST_LOCAL_SP: assert property (
      !i_remote_mode && !$past(i_remote_mode) |->
         $stable(o_active_setpoint) && $stable(o_working_setpoint_one))
      else $error("setting changed outside remote mode");
   AST_LOCAL_NV: assert property (
      !i_remote_mode && !$past(i_remote_mode) |-> !o_nv_store)
      else $error("store pulse outside remote mode");
   AST_CODES: assert property (
      o_active_setpoint != 2'h3 && o_tuning_mode != 2'h3)
      else $error("illegal setpoint or tuning code");
   AST_NV_PULSE: assert property (
      o_nv_store |=> !o_nv_store)
      else $error("store pulse longer than one cycle");
   AST_NV_CAUSE: assert property (
      $changed(o_working_setpoint_one) || $changed(o_active_setpoint)
         |-> o_nv_store)
      else $error("setting changed without store pulse");
endmodule

bind remote_command_interpreter rci_props #(.VAL_W(VAL_W)) i_rci_props (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
   .i_rx_data(i_rx_data), .i_tx_ready(i_tx_ready),
   .i_remote_mode(i_remote_mode), .i_alarm(i_alarm),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_run(o_run),
   .o_remote_stopped(o_remote_stopped),
   .o_active_setpoint(o_active_setpoint), .o_tuning_mode(o_tuning_mode),
   .o_working_setpoint_one(o_working_setpoint_one),
   .o_alarm_relay(o_alarm_relay), .o_nv_store(o_nv_store));

/* File: tb/host_model.sv */
// Host computer model: frame sender and reply sink
module host_model #(
   parameter int GAP = 20
) (
   input  wire logic i_core_clk,
   input  wire logic i_slow,
   input  wire logic i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic      o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic      o_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data  = 8'h00;
      o_tx_ready = 1'b1;
   end
   // Prompt, or stall every other cycle
   always @(posedge i_core_clk) o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
   always @(posedge i_core_clk) begin
      if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
   end
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge i_core_clk);
         o_rx_valid <= 1'b1;
         o_rx_data  <= s[i];
      end
      @(posedge i_core_clk);
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~o_rx_data;
      repeat (GAP) @(posedge i_core_clk);
   endtask
endmodule

/* File: tb/remote_command_interpreter_test.sv */
// Self-checking bench of the remote command interpreter
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t %0h %0h", $time, (a), (b)); end end
module remote_command_interpreter_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk, i_rst, rx_valid, tx_ready, remote, md, alarm, slow;
   logic tx_valid, run, stopped, prog_cur, ext, relay, nv;
   logic [7:0] rx_data, tx_data;
   logic [9:0] addr;
   logic [1:0] act, tune;
   logic [19:0] sp1, sp2, sp3;
   int m_sp[3], m_act, m_tune, m_prog, m_src, m_run, bad_count, n_checks, cyc;
   integer seed = 32'h7a841eba;
   remote_command_interpreter i_remote_command_interpreter (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rx_valid(rx_valid),
      .i_rx_data(rx_data), .i_tx_ready(tx_ready), .i_remote_mode(remote),
      .i_multidrop(md), .i_dev_addr(addr), .i_alarm(alarm),
      .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_run(run),
      .o_remote_stopped(stopped), .o_active_setpoint(act),
      .o_tuning_mode(tune), .o_prog_input_current(prog_cur),
      .o_ext_control(ext), .o_working_setpoint_one(sp1),
      .o_working_setpoint_two(sp2), .o_working_setpoint_three(sp3),
      .o_alarm_relay(relay), .o_nv_store(nv));
   host_model i_host_model (
      .i_core_clk(i_core_clk), .i_slow(slow), .i_tx_valid(tx_valid),
      .i_tx_data(tx_data), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
      .o_tx_ready(tx_ready));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) alarm <= !i_rst && ($random(seed) & 1);
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         print_verdict();
      end
   end
   // ---------------
   // Bench tasks
   // ---------------
   task automatic print_verdict();
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic string fmt(int v);
      int a;
      string sg;
      a = v < 0 ? -v : v;
      sg = "";
      if (v < 0) sg = "-";
      return $sformatf("%s%0d.%02d", sg, a / 100, a % 100);
   endfunction
   task automatic check();
      `CHK(act, 2'(m_act))
      `CHK(tune, 2'(m_tune))
      `CHK(prog_cur, 1'(m_prog))
      `CHK(ext, 1'(m_src))
      `CHK(run, 1'(m_run))
      `CHK(stopped, 1'(remote && m_run == 0))
      `CHK(sp1, 20'(m_sp[0]))
      `CHK(sp2, 20'(m_sp[1]))
      `CHK(sp3, 20'(m_sp[2]))
   endtask
   task automatic frame(string body, bit good);
      int a;
      string s;
      a = good ? int'(addr) : (int'(addr) + 1) % 1000;
      s = md ? $sformatf("A%03d_", a) : "";
      i_host_model.send({s, body, "\r"});
   endtask
   task automatic mode(int c, int p);
      frame($sformatf("out_mode_0%0d %0d", c, p), 1'b1);
      if (remote) begin
         case (c)
            1: m_act = p;
            2: m_tune = p;
            3: m_prog = p;
            4: m_src = p;
            default: m_run = p;
         endcase
      end
      check();
   endtask
   task automatic setsp(int k, int v, bit good);
      frame($sformatf("out_sp_0%0d %s", k, fmt(v)), good);
      if (remote && good) m_sp[k] = v;
      check();
   endtask
   task automatic query(int k, bit good);
      string e;
      int n;
      i_host_model.got.delete();
      frame($sformatf("in_sp_0%0d", k), good);
      e = {md ? $sformatf("A%03d_", addr) : "", fmt(m_sp[k]), "\n"};
      if (!good) e = "";
      while (n < 3000 && e.len() > 0 && (i_host_model.got.size() == 0
             || i_host_model.got[$] !== 8'h0a)) begin
         @(posedge i_core_clk);
         n++;
      end
      repeat (20) @(posedge i_core_clk);
      `CHK(i_host_model.got.size(), e.len())
      for (int i = 0; i < e.len() && i < i_host_model.got.size(); i++)
         `CHK(i_host_model.got[i], e[i])
   endtask
   // ---------------
   // Main sequence
   // ---------------
   initial begin
      {i_rst, remote, md, slow, alarm, addr} = {1'b1, 14'h0000};
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      check();
      setsp(0, 5550, 1'b1);
      mode(1, 2);
      remote <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      check();
      for (int c = 1; c < 5; c++)
         for (int p = 0; p <= (c < 3 ? 2 : 1); p++) mode(c, p);
      mode(1, 1);
      mode(5, 1);
      remote <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      remote <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      m_run = 0;
      check();
      for (int i = 0; i < 6; i++) begin
         slow <= i[0];
         setsp(i % 3, $random(seed) % 100000, 1'b1);
         query(i % 3, 1'b1);
      end
      md <= 1'b1;
      addr <= 10'($unsigned($random(seed)) % 1000);
      @(posedge i_core_clk);
      setsp(0, 777, 1'b0);
      query(0, 1'b0);
      setsp(0, -12345, 1'b1);
      query(0, 1'b1);
      print_verdict();
   end
endmodule
